// ===== design/vectored_interrupt_sequencer.sv
// Vectored interrupt sequencer with program counter and return stack
//
// Contract
// RL1: Interrupt needs request flag, source enable and global enable all set.
// RL2: Enable instruction sets global enable; disable instruction clears it.
// RL3: Taking any interrupt clears global enable until re-enabled by software.
// RL4: Source enable 1 takes interrupts; 0 makes the skip test effective.
// RL5: Request flags set on their condition even when masked, and hold.
// RL6: Flags except voltage-drop clear on interrupt taken or skip executed.
// RL7: Voltage-drop flag cannot clear while its condition is present.
// RL8: A flag already set is taken once masking is lifted.
// RL9: Priority: pin first, then timer one, two, three.
// RL10: Vectors in page 1: pin 0, timer one 4, two 6, three 8.
// RL11: Page 1 words 0080 to 00FF are kept for vector locations.
// RL12: Taking an interrupt pushes the resume address on the stack.
// RL13: Taking an interrupt clears only the serviced source's flag.
// RL14: Taking an interrupt saves pointer, carry, skip and both registers.
// RL15: Counter advances by instruction length or loads a target.
// RL16: Counter splits into page field above bit 7 and word bits 6-0; the code's page field is bits 12-7.
// RL17: Past word 127 the counter continues at word 0 of next page.
// RL18: Program memory has 128-word pages, 48 pages numbered 0 to 47.
// RL19: Enable takes effect only after one further instruction.
// RL20: Interrupt begins 2 cycles after conditions, 3 during multi-cycle.
// RL21: Return-from-interrupt pops resume address and restores saved context.
`timescale 1ns/1ns
`include "irq_seq_defines.svh"
module vectored_interrupt_sequencer (
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  input  wire irq_seq_pkg::instr_t  instr,
  input  wire irq_seq_pkg::ctx_t    ctx_in,
  input  wire logic                 external_irq_pin,
  input  wire logic                 vdrop_detect,
  input  wire logic [`NSRC-1:1]     timer_underflow,
  input  wire logic [1:0]           addr,
  input  wire logic [7:0]           wdata,
  input  wire logic                 wr,
  input  wire logic                 rd,
  output logic [7:0]                rdata,
  output logic [`PC_W-1:0]          pc_r,
  output logic                      irq_taken,
  output logic                      skip_hit,
  output logic                      ctx_restore,
  output irq_seq_pkg::ctx_t         ctx_out,
  output logic [`SP_W-1:0]          stack_ptr
);
  import irq_seq_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [3:0]            irq_control_reg_a;
  logic [3:0]            irq_control_reg_b;
  logic [1:0]            edge_sel_r;
  logic                  global_irq_enable_flag;
  logic                  ei_pending_r;
  logic [`NSRC-1:0]      req_flag_r;
  logic                  vdrop_flag_r;
  logic [`NSRC-1:0]      src_en;
  logic [`NSRC-1:0]      eligible;
  logic [`NSRC-1:0]      set_ev;
  logic [`NSRC-1:0]      skip_clr;
  logic [`NSRC-1:0]      take_onehot;
  logic [`PC_W-1:0]      vector;
  logic                  cond_met;
  logic                  take;
  take_state_t           state_r;
  logic                  multi_r;
  logic [2:0]            pin_sync_r;
  logic [1:0]            vdrop_sync_r;
  logic [`PC_W-1:0]      stack_mem [`STACK_DEPTH];
  logic [`PC_W-1:0]      seq_pc;
  logic [`PC_W-1:0]      top_entry;
  logic [`PAGE_W-1:0]    pc_page_field;
  logic [`WORD_W-1:0]    pc_word_field;
  ctx_t                  irq_context_save;

  // Program counter split into page field and word field
  assign pc_page_field = pc_r[`PC_W-1:`WORD_W];  // RL16 RL18
  assign pc_word_field = pc_r[`WORD_W-1:0];  // RL16

  // ----------------------------------------------------------------
  // Input synchronisers and edge detection
  // ----------------------------------------------------------------
  // Two flops guard against metastability; the third exists only for
  // the edge compare and is never read by anything else.
  // A pin pulse shorter than one core clock may be missed.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_sync_r   <= 3'h0;
      vdrop_sync_r <= 2'h0;
    end else begin
      pin_sync_r   <= {pin_sync_r[1:0], external_irq_pin};
      vdrop_sync_r <= {vdrop_sync_r[0], vdrop_detect};
    end
  end

  always_comb begin
    set_ev = {timer_underflow, 1'b0};
    set_ev[`SRC_PIN] =
      (edge_sel_r[`EDGE_FALL] & pin_sync_r[2] & ~pin_sync_r[1]) |
      (edge_sel_r[`EDGE_RISE] & ~pin_sync_r[2] & pin_sync_r[1]);
  end

  // ----------------------------------------------------------------
  // Enables, eligibility and priority
  // ----------------------------------------------------------------
  assign src_en = {irq_control_reg_b[`CTL_B_T3],
                   irq_control_reg_a[`CTL_A_T2],
                   irq_control_reg_a[`CTL_A_T1],
                   irq_control_reg_a[`CTL_A_PIN]};
  assign eligible = req_flag_r & src_en;  // RL1 RL4
  assign cond_met = global_irq_enable_flag & (|eligible);  // RL1 RL8

  // Lowest index wins, so the pin outranks every timer
  always_comb begin
    take_onehot = '0;
    vector      = `VEC_PIN;
    if (eligible[`SRC_PIN]) begin  // RL9
      take_onehot[`SRC_PIN] = 1'b1;
      vector = `VEC_PIN;  // RL10 RL11
    end else if (eligible[`SRC_T1]) begin
      take_onehot[`SRC_T1] = 1'b1;
      vector = `VEC_T1;  // RL10
    end else if (eligible[`SRC_T2]) begin
      take_onehot[`SRC_T2] = 1'b1;
      vector = `VEC_T2;  // RL10
    end else if (eligible[`SRC_T3]) begin
      take_onehot[`SRC_T3] = 1'b1;
      vector = `VEC_T3;  // RL10
    end
  end

  // ----------------------------------------------------------------
  // Take timing
  // ----------------------------------------------------------------
  // Conditions meet in cycle 0; take fires in cycle 1, or in cycle 2
  // when the instruction then in flight is multi-cycle. Losing any
  // condition before take abandons the attempt with no side effect.
  // The core must insert the vector fetch on the cycle irq_taken is high
  assign take = cond_met &&
                ((state_r == S_ARM && !multi_r) || state_r == S_LATE);  // RL20

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= S_IDLE;
      multi_r <= 1'b0;
    end else if (!cond_met || take) begin
      state_r <= S_IDLE;
    end else begin
      unique case (state_r)
        S_IDLE: begin
          state_r <= S_ARM;
          multi_r <= instr.multi;  // RL20
        end
        S_ARM:  state_r <= S_LATE;
        S_LATE: state_r <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_taken <= 1'b0;
    end else begin
      irq_taken <= take;
    end
  end

  // ----------------------------------------------------------------
  // Global enable with one-instruction delay
  // ----------------------------------------------------------------
  // The enable instruction only arms a pending bit; the next retire makes
  // it count, so an enable just before return lands in the resumed code
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      global_irq_enable_flag <= 1'b0;
      ei_pending_r           <= 1'b0;
    end else if (take) begin
      global_irq_enable_flag <= 1'b0;  // RL3
      ei_pending_r           <= 1'b0;
    end else if (instr.done) begin
      if (instr.di) begin
        global_irq_enable_flag <= 1'b0;  // RL2
        ei_pending_r           <= 1'b0;
      end else if (instr.ei) begin
        ei_pending_r <= 1'b1;  // RL19
      end else if (ei_pending_r) begin
        global_irq_enable_flag <= 1'b1;  // RL2 RL19
        ei_pending_r           <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Request flags
  // ----------------------------------------------------------------
  // Set wins over clear in one cycle, so no event is ever lost
  // A skip test is only effective while its source enable is low
  assign skip_clr = instr.skip_test & ~src_en & {`NSRC{instr.done}};  // RL4

  generate
    for (genvar i = 0; i < `NSRC; i++) begin : g_flag
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          req_flag_r[i] <= 1'b0;
        end else if (set_ev[i]) begin
          req_flag_r[i] <= 1'b1;  // RL5
        end else if ((take && take_onehot[i]) || skip_clr[i]) begin
          req_flag_r[i] <= 1'b0;  // RL6 RL13
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      vdrop_flag_r <= 1'b0;
    end else if (vdrop_sync_r[1]) begin
      vdrop_flag_r <= 1'b1;  // RL5 RL7
    end else if (instr.done && instr.skip_vdrop) begin
      vdrop_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      skip_hit <= 1'b0;
    end else if (instr.done) begin
      skip_hit <= (|(skip_clr & req_flag_r)) |
                  (instr.skip_vdrop & vdrop_flag_r);  // RL4
    end else begin
      skip_hit <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Program counter and return stack
  // ----------------------------------------------------------------
  assign top_entry = stack_mem[stack_ptr - `SP_W'(1)];
  // Binary add carries word 127 into the next page; no page limit is
  // enforced, so software must keep the counter from running past the last page
  assign seq_pc = {pc_page_field, pc_word_field} +
                  `PC_W'(instr.len);  // RL15 RL17

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pc_r      <= '0;
      stack_ptr <= '0;
    end else if (take) begin
      pc_r      <= vector;  // RL10
      stack_ptr <= stack_ptr + `SP_W'(1);  // RL12
    end else if (instr.done) begin
      if (instr.return_from_irq_instr || instr.ret) begin
        pc_r      <= top_entry;  // RL15 RL21
        stack_ptr <= stack_ptr - `SP_W'(1);
      end else if (instr.call || instr.tabp) begin
        pc_r      <= instr.target;  // RL15
        stack_ptr <= stack_ptr + `SP_W'(1);
      end else if (instr.jump) begin
        pc_r <= instr.target;  // RL15
      end else begin
        pc_r <= seq_pc;  // RL15 RL17
      end
    end
  end

  // A take beside a retire saves the word after that instruction;
  // otherwise the counter already points at the resume word.
  // Overflow past eight levels overwrites the oldest entry
  always_ff @(posedge clk) begin
    if (take) begin
      stack_mem[stack_ptr] <= instr.done ? seq_pc : pc_r;  // RL12
    end else if (instr.done && (instr.call || instr.tabp)) begin
      stack_mem[stack_ptr] <= seq_pc;
    end
  end

  // ----------------------------------------------------------------
  // Context save and restore
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_context_save <= '0;
    end else if (take) begin
      irq_context_save <= ctx_in;  // RL14
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctx_out     <= '0;
      ctx_restore <= 1'b0;
    end else begin
      ctx_restore <= instr.done && instr.return_from_irq_instr && !take;  // RL21
      if (instr.done && instr.return_from_irq_instr && !take) begin
        ctx_out <= irq_context_save;  // RL21
      end
    end
  end

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  // Address 0: bit 0 pin enable, bit 1 spare, bits 2 and 3 timer one, two
  // Address 1: bit 0 timer three enable, bits 3 to 1 spare
  // Address 2: bit 0 takes falling edges, bit 1 rising, both for either
  // Address 3: read-only status; writes there are dropped on purpose
  // Spare bits read back what was written so software may use them
  // Read data is zero outside its one cycle, so ports can be OR-ed upstream
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_control_reg_a <= `CTL_RST;
      irq_control_reg_b <= `CTL_RST;
      edge_sel_r        <= `EDGE_RST;
    end else if (wr) begin
      unique case (addr)
        `ADDR_CTL_A:  irq_control_reg_a <= wdata[3:0];
        `ADDR_CTL_B:  irq_control_reg_b <= wdata[3:0];
        `ADDR_EDGE:   edge_sel_r        <= wdata[1:0];
        `ADDR_STATUS: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= 8'h00;
    end else if (rd) begin
      unique case (addr)
        `ADDR_CTL_A:  rdata <= {4'h0, irq_control_reg_a};
        `ADDR_CTL_B:  rdata <= {4'h0, irq_control_reg_b};
        `ADDR_EDGE:   rdata <= {6'h00, edge_sel_r};
        `ADDR_STATUS: rdata <= {2'h0, global_irq_enable_flag,
                                vdrop_flag_r, req_flag_r};
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

endmodule : vectored_interrupt_sequencer

// ===== design/irq_seq_defines.svh
// Constants for the vectored interrupt sequencer
`ifndef IRQ_SEQ_DEFINES_SVH
`define IRQ_SEQ_DEFINES_SVH
`define PC_W          13
`define PAGE_W        6
`define WORD_W        7
`define PAGE_LAST     6'h2f
`define STACK_DEPTH   8
`define SP_W          3
`define NSRC          4
`define SRC_PIN       0
`define SRC_T1        1
`define SRC_T2        2
`define SRC_T3        3
`define VEC_PIN       13'h0080
`define VEC_T1        13'h0084
`define VEC_T2        13'h0086
`define VEC_T3        13'h0088
`define VEC_BASE      13'h0080
`define VEC_LIMIT     13'h00ff
`define ADDR_CTL_A    2'h0
`define ADDR_CTL_B    2'h1
`define ADDR_EDGE     2'h2
`define ADDR_STATUS   2'h3
`define CTL_A_PIN     0
`define CTL_A_T1      2
`define CTL_A_T2      3
`define CTL_B_T3      0
`define CTL_RST       4'h0
`define EDGE_RST      2'h1
`define EDGE_FALL     0
`define EDGE_RISE     1
`endif

// ===== design/irq_seq_pkg.sv
// Types shared by the vectored interrupt sequencer
`include "irq_seq_defines.svh"
package irq_seq_pkg;
  typedef struct packed {
    logic              done;
    logic              multi;
    logic              ei;
    logic              di;
    logic              return_from_irq_instr;
    logic              ret;
    logic              call;
    logic              jump;
    logic              tabp;
    logic [`NSRC-1:0]  skip_test;
    logic              skip_vdrop;
    logic [1:0]        len;
    logic [`PC_W-1:0]  target;
  } instr_t;
  typedef struct packed {
    logic [8:0] dp;
    logic       carry;
    logic       skip;
    logic [3:0] acc;
    logic [3:0] aux;
  } ctx_t;
  typedef enum logic [1:0] {S_IDLE, S_ARM, S_LATE} take_state_t;
endpackage : irq_seq_pkg

// ===== verification/cpu_irq_partner.sv
// Model of the core sequencer and the interrupt sources
`timescale 1ns/1ns
`include "irq_seq_defines.svh"
module cpu_irq_partner (
  input  wire logic           clk,
  output irq_seq_pkg::instr_t instr,
  output irq_seq_pkg::ctx_t   ctx_in,
  output logic                external_irq_pin,
  output logic                vdrop_detect,
  output logic [`NSRC-1:1]    timer_underflow
);
  import irq_seq_pkg::*;
  initial begin
    instr = '0;
    ctx_in = '0;
    external_irq_pin = 1'b1;
    vdrop_detect = 1'b0;
    timer_underflow = '0;
  end
  // One retire per call, so done never stands two cycles; multi stays up
  // after the retire, standing for the next instruction in flight
  task automatic exec(input instr_t i, input ctx_t c);
    instr_t nxt;
    nxt = '0;
    nxt.multi = i.multi;
    i.done = 1'b1;
    @(posedge clk);
    instr <= i;
    ctx_in <= c;
    @(posedge clk);
    instr <= nxt;
  endtask : exec
  task automatic tick(input logic [`NSRC-1:1] m);
    @(posedge clk);
    timer_underflow <= m;
    @(posedge clk);
    timer_underflow <= '0;
  endtask : tick
  // Held well past the one-cycle minimum width at the pin
  task automatic level(input logic pin, input logic vd);
    @(posedge clk);
    external_irq_pin <= pin;
    vdrop_detect <= vd;
    repeat (6) @(posedge clk);
  endtask : level
endmodule : cpu_irq_partner

// ===== verification/vectored_interrupt_sequencer_sva.sv
// Checker on the ports of the vectored interrupt sequencer
`timescale 1ns/1ns
`include "irq_seq_defines.svh"
module irq_seq_chk (
  input wire logic                clk,
  input wire logic                rst_b,
  input wire irq_seq_pkg::instr_t instr,
  input wire logic                rd,
  input wire logic [7:0]          rdata,
  input wire logic [`PC_W-1:0]    pc_r,
  input wire logic                irq_taken,
  input wire logic                ctx_restore,
  input wire logic [`SP_W-1:0]    stack_ptr
);
  import irq_seq_pkg::*;
  // Retire with no branch or skip test: only the length moves the counter
  wire plain = instr.done & ~(instr.return_from_irq_instr | instr.ret | instr.call
    | instr.jump | instr.tabp | instr.skip_vdrop | (|instr.skip_test));
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_vector;
    irq_taken |-> pc_r inside {`VEC_PIN, `VEC_T1, `VEC_T2, `VEC_T3};
  endproperty
  a_vector: assert property (p_vector) else $error("bad vector");
  property p_vec_range;
    irq_taken |-> pc_r >= `VEC_BASE && pc_r <= `VEC_LIMIT;
  endproperty
  a_vec_range: assert property (p_vec_range) else $error("range");
  property p_retake;
    irq_taken |=> !irq_taken [*3];
  endproperty
  a_retake: assert property (p_retake) else $error("retake");
  property p_push;
    irq_taken |-> stack_ptr == $past(stack_ptr) + 1'b1;
  endproperty
  a_push: assert property (p_push) else $error("no push");
  property p_sp_hold;
    !instr.done ##1 !irq_taken |-> $stable(stack_ptr);
  endproperty
  a_sp_hold: assert property (p_sp_hold) else $error("sp moved");
  property p_restore;
    instr.done && instr.return_from_irq_instr |=> ctx_restore;
  endproperty
  a_restore: assert property (p_restore) else $error("no restore");
  property p_pop;
    ctx_restore |-> stack_ptr == $past(stack_ptr) - 1'b1;
  endproperty
  a_pop: assert property (p_pop) else $error("no pop");
  property p_advance;
    plain |=> irq_taken || pc_r == $past(pc_r) + $past(instr.len);
  endproperty
  a_advance: assert property (p_advance) else $error("advance");
  property p_jump;
    instr.done && instr.jump |=> irq_taken || pc_r == $past(instr.target);
  endproperty
  a_jump: assert property (p_jump) else $error("jump");
  property p_wrap;
    plain && pc_r[6:0] == 7'h7f && instr.len == 2'h1 |=> irq_taken
      || pc_r[6:0] == 7'h00 && pc_r[12:7] == $past(pc_r[12:7]) + 1'b1;
  endproperty
  a_wrap: assert property (p_wrap) else $error("page wrap");
  property p_rd_quiet;
    !rd |=> rdata == 8'h00;
  endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("stray data");
  c_pin: cover property (irq_taken && pc_r == `VEC_PIN);
  c_restore: cover property (ctx_restore);
  c_wrap: cover property (plain && pc_r[6:0] == 7'h7f);
endmodule : irq_seq_chk
bind vectored_interrupt_sequencer irq_seq_chk u_chk (.clk(clk),
  .rst_b(rst_b), .instr(instr), .rd(rd), .rdata(rdata), .pc_r(pc_r),
  .irq_taken(irq_taken), .ctx_restore(ctx_restore), .stack_ptr(stack_ptr));

// ===== verification/vectored_interrupt_sequencer_bench.sv
// Self-checking bench for the vectored interrupt sequencer
`timescale 1ns/1ns
`include "irq_seq_defines.svh"
module vectored_interrupt_sequencer_bench;
  import irq_seq_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, rd_seen = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00, rdata;
  instr_t instr, i;
  ctx_t ctx_in, ctx_out, c;
  logic ext_pin, vdrop, irq_taken, skip_hit, ctx_restore;
  logic [`NSRC-1:1] tmr;
  logic [`PC_W-1:0] pc_r;
  logic [`SP_W-1:0] stack_ptr;
  int n_mismatch = 0, checked = 0;
  logic [7:0] rd_q[$];
  logic [`PC_W-1:0] vec_q[$];
  ctx_t ctx_q[$];
  logic skip_q[$];
  int at_q[$];
  int cyc = 0;
  always #5 clk = ~clk;
  cpu_irq_partner u_cpu (.clk(clk), .instr(instr), .ctx_in(ctx_in),
    .external_irq_pin(ext_pin), .vdrop_detect(vdrop), .timer_underflow(tmr));
  vectored_interrupt_sequencer dut (.clk(clk), .rst_b(rst_b), .instr(instr),
    .ctx_in(ctx_in), .external_irq_pin(ext_pin), .vdrop_detect(vdrop),
    .timer_underflow(tmr), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .pc_r(pc_r), .irq_taken(irq_taken), .skip_hit(skip_hit),
    .ctx_restore(ctx_restore), .ctx_out(ctx_out), .stack_ptr(stack_ptr));
  task automatic fail(input string m);
    n_mismatch++;
    $display("mismatch at %0t: %s", $time, m);
  endtask : fail
  task automatic cmp_rd;
    checked++;
    if (rd_q.size() == 0 || rdata !== rd_q.pop_front()) fail("read data");
  endtask : cmp_rd
  task automatic cmp_vec;
    checked++;
    if (vec_q.size() == 0 || pc_r !== vec_q.pop_front()) fail("vector");
  endtask : cmp_vec
  task automatic cmp_ctx;
    checked++;
    if (ctx_q.size() == 0 || ctx_out !== ctx_q.pop_front()) fail("context");
  endtask : cmp_ctx
  task automatic cmp_skip;
    checked++;
    if (skip_q.size() == 0 || skip_hit !== skip_q.pop_front()) fail("skip");
  endtask : cmp_skip
  task automatic cmp_lat;
    checked++;
    if (at_q.size() == 0 || cyc != at_q.pop_front()) fail("latency");
  endtask : cmp_lat
  // An unexpected interrupt finds an empty queue and counts as a mismatch
  always @(posedge clk) begin
    rd_seen <= rd;
    cyc <= cyc + 1;
    if (rd_seen) cmp_rd();
    if (irq_taken === 1'b1) cmp_vec();
    if (irq_taken === 1'b1) cmp_lat();
    if (ctx_restore === 1'b1) cmp_ctx();
    if (skip_hit === 1'b1) cmp_skip();
  end
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [1:0] a, input logic [7:0] e);
    rd_q.push_back(e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
  endtask : rd_reg
  function automatic instr_t op(input logic [2:0] cls, input logic [3:0] sk,
                                input logic vd);
    instr_t r;
    r = '0;
    {r.ei, r.di, r.return_from_irq_instr} = cls;
    r.skip_test = sk;
    r.skip_vdrop = vd;
    r.len = 2'h1;
    return r;
  endfunction : op
  // Enable counts after one more retire; a take then shows three cycles
  // after that retire, four when the instruction in flight is multi-cycle
  task automatic arm(input logic m, input logic t);
    instr_t w;
    w = op(3'b000, 4'h0, 1'b0);
    w.multi = m;
    u_cpu.exec(op(3'b100, 4'h0, 1'b0), c);
    repeat (5) @(posedge clk);
    u_cpu.exec(w, c);
    if (t) at_q.push_back(m ? cyc + 4 : cyc + 3);
    repeat (6) @(posedge clk);
  endtask : arm
  task automatic end_sim;
    if (rd_q.size() + vec_q.size() + ctx_q.size() + skip_q.size()
        + at_q.size() != 0) fail("result lost");
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim
  initial begin
    #100000;
    fail("watchdog");
    end_sim();
  end
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(32'h420f_36be));
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd_reg(`ADDR_CTL_A, 8'h00);
    rd_reg(`ADDR_CTL_B, 8'h00);
    rd_reg(`ADDR_EDGE, 8'h01);
    rd_reg(`ADDR_STATUS, 8'h00);
    $display("test reset values done");
    u_cpu.tick(3'b111);
    rd_reg(`ADDR_STATUS, 8'h0e);
    skip_q.push_back(1'b1);
    u_cpu.exec(op(3'b000, 4'b0100, 1'b0), c);
    rd_reg(`ADDR_STATUS, 8'h0a);
    wr_reg(`ADDR_CTL_A, 8'h0c);
    wr_reg(`ADDR_CTL_B, 8'h01);
    u_cpu.exec(op(3'b000, 4'b0010, 1'b0), c);
    wr_reg(`ADDR_STATUS, 8'hff);
    rd_reg(`ADDR_STATUS, 8'h0a);
    $display("test masked flags done");
    for (int k = 0; k < 2; k++) begin
      c = ctx_t'($bits(ctx_t)'($urandom));
      vec_q.push_back(k ? `VEC_T3 : `VEC_T1);
      ctx_q.push_back(c);
      arm(k == 1, 1'b1);
      rd_reg(`ADDR_STATUS, k ? 8'h00 : 8'h08);
      u_cpu.exec(op(3'b001, 4'h0, 1'b0), c);
    end
    $display("test priority done");
    wr_reg(`ADDR_CTL_A, 8'h01);
    arm(1'b0, 1'b0);
    rd_reg(`ADDR_STATUS, 8'h20);
    u_cpu.exec(op(3'b010, 4'h0, 1'b0), c);
    u_cpu.level(1'b0, 1'b0);
    rd_reg(`ADDR_STATUS, 8'h01);
    vec_q.push_back(`VEC_PIN);
    ctx_q.push_back(c);
    arm(1'b0, 1'b1);
    u_cpu.exec(op(3'b001, 4'h0, 1'b0), c);
    $display("test pin done");
    wr_reg(`ADDR_EDGE, 8'h03);
    wr_reg(`ADDR_CTL_A, 8'h00);
    u_cpu.level(1'b1, 1'b1);
    skip_q.push_back(1'b1);
    u_cpu.exec(op(3'b000, 4'h0, 1'b1), c);
    rd_reg(`ADDR_STATUS, 8'h11);
    u_cpu.level(1'b1, 1'b0);
    skip_q.push_back(1'b1);
    u_cpu.exec(op(3'b000, 4'h0, 1'b1), c);
    rd_reg(`ADDR_STATUS, 8'h01);
    skip_q.push_back(1'b1);
    u_cpu.exec(op(3'b000, 4'b0001, 1'b0), c);
    rd_reg(`ADDR_STATUS, 8'h00);
    u_cpu.level(1'b0, 1'b0);
    rd_reg(`ADDR_STATUS, 8'h01);
    i = op(3'b000, 4'h0, 1'b0);
    i.jump = 1'b1;
    i.target = 13'h017f;
    u_cpu.exec(i, c);
    u_cpu.exec(op(3'b000, 4'h0, 1'b0), c);
    $display("test voltage drop and wrap done");
    repeat (4) @(posedge clk);
    end_sim();
  end
endmodule : vectored_interrupt_sequencer_bench
